// ---- verilog/vc_router_params.svh ----
/*
 * Offsets, field positions, reset values and limits of the upstream VC set router.
 * Assumes a 32-bit APB3 register bus with byte addresses.
 */
`ifndef VC_ROUTER_PARAMS_SVH
`define VC_ROUTER_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_MODE 8'h00
`define OFS_TUNE 8'h04
`define OFS_STATUS 8'h08
`define OFS_CNT_BASE 8'h10
`define CNT_WORDS 10
`define CNT_PER_WORD 4

// ****************************************
// mode and status bit positions
// ****************************************
`define MODE_DR_BIT 0
`define MODE_HP_BIT 1
`define MODE_ISOC_BIT 2
`define MODE_DEMOTE_BIT 3
`define STAT_VIOL_BIT 0
`define STAT_DR_BIT 4
`define STAT_HP_BIT 5
`define STAT_ISOC_BIT 6
`define STAT_DEMOTE_BIT 7

// ****************************************
// reset values
// ****************************************
`define MODE_RST 4'h0
`define TUNE_RST 32'h00000000
`define CNT_RST 6'h00

// ****************************************
// count field indices, four per word, one per byte lane
// ****************************************
`define C_UP_P 0
`define C_UP_NPC 1
`define C_UP_RC 2
`define C_UP_RD 3
`define C_UP_NPD 4
`define C_ISO_P 5
`define C_ISO_NPC 6
`define C_ISO_RC 7
`define C_ISO_RD 8
`define C_ISO_NPD 9
`define C_DN_HI_R 10
`define C_DN_HI_NP 11
`define C_DN_HI_P 12
`define C_DN_LO_R 13
`define C_DN_LO_NP 14
`define C_DN_LO_P 15
`define C_DN_POOL 16
`define C_DN_DR_R 17
`define C_NB_LO_PD 18
`define C_NB_LO_NPD 19
`define C_NB_HI_PD 20
`define C_NB_HI_NPD 21
`define C_NB_LO_RC 22
`define C_NB_HI_RC 23
`define C_NB_LO_PC 24
`define C_NB_LO_NPC 25
`define C_NB_HI_PC 26
`define C_NB_HI_NPC 27
`define C_NB_DR_C 28
`define C_FREE 29
`define C_IF_DR 30
`define C_IF_HI_P 31
`define C_IF_HI_NP 32
`define C_IF_LO_P 33
`define C_IF_LO_NP 34
`define C_IF_CORE 35
`define C_NB_LO_RD 36
`define C_NB_HI_RD 37

// ****************************************
// allocation limits
// ****************************************
`define LIM_UP_CMD 9'h024
`define LIM_UP_DATA 9'h014
`define LIM_DN 9'h022
`define LIM_NB_DATA 9'h008
`define LIM_NB_RSP 9'h008
`define LIM_NB_REQ 9'h010
`define LIM_INFLIGHT 9'h010

`endif

// ---- verilog/vc_router_pkg.sv ----
/*
 * Types of the upstream VC set router.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package vc_router_pkg;
    typedef enum logic [1:0] {
        CLS_BASE = 2'h0,
        CLS_DISP = 2'h1,
        CLS_ISOC = 2'h2
    } req_class_t;
    typedef enum logic [1:0] {
        VC_LO = 2'h0,
        VC_DR = 2'h1,
        VC_HI = 2'h2
    } vc_set_t;
    typedef enum logic [1:0] {
        SUB_POSTED = 2'h0,
        SUB_NONPOSTED = 2'h1,
        SUB_RESP = 2'h2
    } subch_t;
    typedef enum logic [1:0] {
        DN_CORE = 2'h0,
        DN_PEER = 2'h1,
        DN_RESP = 2'h2
    } dn_src_t;
endpackage

// ---- verilog/vc_set_classifier.sv ----
/*
 * One registered stage that classifies upstream requests onto VC sets and
 * picks the link channel of downstream traffic.
 * Assumes request inputs come from logic on the same clock.
 */
module vc_set_classifier (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic dr_en_i,
    input wire logic hp_en_i,
    input wire logic demote_en_i,
    input wire logic req_valid_i,
    input wire logic req_isoc_i,
    input wire logic req_posted_i,
    input wire logic req_read_i,
    input wire logic req_ppw_i,
    input wire logic req_rppw_i,
    input wire logic req_coherent_i,
    input wire logic [3:0] req_seq_tag_i,
    input wire logic dn_valid_i,
    input wire vc_router_pkg::dn_src_t dn_src_i,
    input wire logic dn_up_isoc_i,
    output vc_router_pkg::req_class_t req_class_o,
    output vc_router_pkg::vc_set_t req_vc_set_o,
    output vc_router_pkg::subch_t req_subch_o,
    output logic req_valid_o,
    output logic dn_valid_o,
    output logic dn_isoc_o
);
    vc_router_pkg::req_class_t cls_nxt;
    vc_router_pkg::vc_set_t set_nxt;
    vc_router_pkg::subch_t sub_nxt;
    logic dn_isoc_nxt;

    // ****************************************
    // classification and mapping
    // ****************************************
    always_comb begin
        // display refresh tested first so it wins over isochronous
        if (req_isoc_i && !req_posted_i && req_read_i && req_ppw_i && req_rppw_i
            && !req_coherent_i && req_seq_tag_i == 4'h0) begin
            cls_nxt = vc_router_pkg::CLS_DISP;
        end else if (req_isoc_i) begin
            cls_nxt = vc_router_pkg::CLS_ISOC;
        end else begin
            cls_nxt = vc_router_pkg::CLS_BASE;
        end
        set_nxt = vc_router_pkg::VC_LO;
        if (cls_nxt == vc_router_pkg::CLS_DISP && dr_en_i) begin
            set_nxt = vc_router_pkg::VC_DR;
        end else if (cls_nxt != vc_router_pkg::CLS_BASE && hp_en_i) begin
            set_nxt = vc_router_pkg::VC_HI;
        end
        // display refresh set has no posted lane; its requests are reads
        sub_nxt = req_posted_i ? vc_router_pkg::SUB_POSTED : vc_router_pkg::SUB_NONPOSTED;
        case (dn_src_i)
            vc_router_pkg::DN_CORE: dn_isoc_nxt = 1'b0;
            vc_router_pkg::DN_PEER: dn_isoc_nxt = dn_up_isoc_i && !demote_en_i;
            vc_router_pkg::DN_RESP: dn_isoc_nxt = dn_up_isoc_i;
            default: dn_isoc_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_class_o <= vc_router_pkg::CLS_BASE;
            req_vc_set_o <= vc_router_pkg::VC_LO;
            req_subch_o <= vc_router_pkg::SUB_POSTED;
            req_valid_o <= 1'b0;
            dn_valid_o <= 1'b0;
            dn_isoc_o <= 1'b0;
        end else begin
            req_class_o <= cls_nxt;
            req_vc_set_o <= set_nxt;
            req_subch_o <= sub_nxt;
            req_valid_o <= req_valid_i;
            dn_valid_o <= dn_valid_i;
            dn_isoc_o <= dn_isoc_nxt;
        end
    end
endmodule // vc_set_classifier

// ---- verilog/upstream_vc_set_router.sv ----
/*
 * Upstream VC set router: APB3 register file, warm-reset commit of the
 * buffer counts, route enables and isoc flow, allocation checks, and request routing.
 * Assumes WARM_RESET_I is asynchronous; request and APB inputs share CLK_I.
 */
// Function
// - display refresh is a nonposted read, isoc, both pass bits, noncoherent, tag zero.
// - an isoc request that is not display refresh is isochronous.
// - a request with isoc clear is a base request.
// - low priority set has posted, nonposted and response lanes.
// - display refresh set has only nonposted and response lanes.
// - high priority set has posted, nonposted and response lanes.
// - core downstream requests always use the base link channel.
// - peer traffic keeps upstream isoc type unless demotion is enabled.
// - a downstream response uses the channel of its request.
// - both enables off send everything low; isoc flow must stay off.
// - refresh enable only sends refresh to its set, rest low.
// - high enable only sends isoc and refresh high, base low.
// - both enables send refresh to its set, isoc high, base low.
// - counts, route enables and isoc flow take effect at warm reset.
// - tuning register takes effect at once.
`include "vc_router_params.svh"
module upstream_vc_set_router #(
    parameter int ADDR_W = 8,
    parameter int CNT_W = 6
) (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic WARM_RESET_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic REQ_VALID_I,
    input wire logic REQ_ISOC_I,
    input wire logic REQ_POSTED_I,
    input wire logic REQ_READ_I,
    input wire logic REQ_PASS_PW_I,
    input wire logic REQ_RESP_PASS_PW_I,
    input wire logic REQ_COHERENT_I,
    input wire logic [3:0] REQ_SEQ_TAG_I,
    input wire logic DN_VALID_I,
    input wire vc_router_pkg::dn_src_t DN_SRC_I,
    input wire logic DN_UP_ISOC_I,
    output logic REQ_VALID_O,
    output vc_router_pkg::req_class_t REQ_CLASS_O,
    output vc_router_pkg::vc_set_t REQ_VC_SET_O,
    output vc_router_pkg::subch_t REQ_SUBCH_O,
    output logic DN_VALID_O,
    output logic DN_ISOC_O,
    output logic [31:0] TUNE_O,
    output logic ISOC_FLOW_EN_O,
    output logic CFG_VIOLATION_O
);
    localparam int NCNT = `CNT_WORDS * `CNT_PER_WORD;

    // ****************************************
    // warm reset synchroniser and edge
    // ****************************************
    logic wr_s1_r, wr_s2_r, wr_s3_r;
    logic warm_edge;

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            wr_s1_r <= 1'b0;
            wr_s2_r <= 1'b0;
            wr_s3_r <= 1'b0;
        end else begin
            wr_s1_r <= WARM_RESET_I;
            wr_s2_r <= wr_s1_r;
            wr_s3_r <= wr_s2_r;
        end
    end
    assign warm_edge = wr_s2_r && !wr_s3_r;

    // ****************************************
    // apb decode
    // ****************************************
    logic setup, wr_acc, hit_cnt, mapped;
    logic [ADDR_W-1:0] cnt_ofs;
    logic [3:0] cnt_word;

    assign setup = PSEL_I && !PENABLE_I;
    assign wr_acc = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && !PSLVERR_O;
    assign cnt_ofs = PADDR_I - ADDR_W'(`OFS_CNT_BASE);
    assign cnt_word = cnt_ofs[5:2];
    assign hit_cnt = PADDR_I[1:0] == 2'h0 && PADDR_I >= ADDR_W'(`OFS_CNT_BASE)
        && cnt_ofs[ADDR_W-1:2] < (ADDR_W-2)'(`CNT_WORDS);
    assign mapped = hit_cnt || PADDR_I == ADDR_W'(`OFS_MODE)
        || PADDR_I == ADDR_W'(`OFS_TUNE) || PADDR_I == ADDR_W'(`OFS_STATUS);

    // ****************************************
    // mode, tuning and count registers
    // ****************************************
    logic [3:0] mode_r, mode_nxt;
    logic [2:0] act_mode_r, act_mode_nxt;
    logic [31:0] tune_nxt;
    logic [CNT_W-1:0] shd_r [NCNT];
    logic [CNT_W-1:0] shd_nxt [NCNT];
    logic [CNT_W-1:0] act_r [NCNT];
    logic [CNT_W-1:0] act_nxt [NCNT];

    always_comb begin
        mode_nxt = mode_r;
        tune_nxt = TUNE_O;
        act_mode_nxt = act_mode_r;
        if (wr_acc && PADDR_I == ADDR_W'(`OFS_MODE)) begin
            mode_nxt = PWDATA_I[3:0];
        end
        if (wr_acc && PADDR_I == ADDR_W'(`OFS_TUNE)) begin
            tune_nxt = PWDATA_I;
        end
        if (warm_edge) begin
            act_mode_nxt = mode_r[2:0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCNT; g++) begin : g_cnt
            always_comb begin
                shd_nxt[g] = shd_r[g];
                act_nxt[g] = act_r[g];
                if (wr_acc && hit_cnt && cnt_word == 4'(g / `CNT_PER_WORD)) begin
                    shd_nxt[g] = PWDATA_I[8*(g%`CNT_PER_WORD) +: CNT_W];
                end
                if (warm_edge) begin
                    act_nxt[g] = shd_r[g];
                end
            end
            always_ff @(posedge CLK_I or posedge RESET_I) begin
                if (RESET_I) begin
                    shd_r[g] <= CNT_W'(`CNT_RST);
                    act_r[g] <= CNT_W'(`CNT_RST);
                end else begin
                    shd_r[g] <= shd_nxt[g];
                    act_r[g] <= act_nxt[g];
                end
            end
        end
    endgenerate

    // ****************************************
    // allocation checks on the values being committed
    // ****************************************
    function automatic logic [8:0] z(input logic [CNT_W-1:0] v);
        return 9'(v);
    endfunction

    logic [8:0] s_up_cmd, s_up_dat, s_dn, s_nb_dat, s_nb_rsp, s_nb_req, s_if;
    logic lo_zero, dr_zero, hi_zero, bad;

    always_comb begin
        s_up_cmd = z(shd_r[`C_UP_NPC]) + z(shd_r[`C_UP_P]) + z(shd_r[`C_UP_RC])
            + z(shd_r[`C_ISO_NPC]) + z(shd_r[`C_ISO_P]) + z(shd_r[`C_ISO_RC]);
        s_up_dat = z(shd_r[`C_UP_RD]) + z(shd_r[`C_UP_NPD]) + z(shd_r[`C_UP_P])
            + z(shd_r[`C_ISO_RD]) + z(shd_r[`C_ISO_NPD]) + z(shd_r[`C_ISO_P]);
        s_dn = z(shd_r[`C_DN_HI_R]) + z(shd_r[`C_DN_HI_NP]) + z(shd_r[`C_DN_HI_P])
            + z(shd_r[`C_DN_LO_R]) + z(shd_r[`C_DN_LO_NP]) + z(shd_r[`C_DN_LO_P])
            + z(shd_r[`C_DN_POOL]);
        s_nb_dat = z(shd_r[`C_NB_LO_PD]) + z(shd_r[`C_NB_LO_NPD])
            + z(shd_r[`C_NB_HI_PD]) + z(shd_r[`C_NB_HI_NPD]);
        s_nb_rsp = z(shd_r[`C_NB_HI_RC]) + z(shd_r[`C_NB_LO_RC]);
        s_nb_req = z(shd_r[`C_NB_HI_PC]) + z(shd_r[`C_NB_HI_NPC]) + z(shd_r[`C_NB_LO_PC])
            + z(shd_r[`C_NB_LO_NPC]) + z(shd_r[`C_NB_DR_C]);
        s_if = z(shd_r[`C_FREE]) + z(shd_r[`C_IF_DR]) + z(shd_r[`C_IF_HI_NP])
            + z(shd_r[`C_IF_HI_P]) + z(shd_r[`C_IF_LO_NP]) + z(shd_r[`C_IF_LO_P])
            + z(shd_r[`C_IF_CORE]);
        lo_zero = shd_r[`C_UP_P] == '0 || shd_r[`C_UP_NPC] == '0 || shd_r[`C_UP_NPD] == '0
            || shd_r[`C_UP_RC] == '0 || shd_r[`C_UP_RD] == '0
            || shd_r[`C_NB_LO_NPD] == '0 || shd_r[`C_NB_LO_RD] == '0
            || shd_r[`C_NB_LO_PD] == '0 || shd_r[`C_NB_LO_RC] == '0
            || shd_r[`C_NB_LO_NPC] == '0 || shd_r[`C_NB_LO_PC] == '0
            || shd_r[`C_IF_LO_P] == '0 || shd_r[`C_IF_LO_NP] == '0;
        dr_zero = shd_r[`C_DN_DR_R] == '0 || shd_r[`C_NB_DR_C] == '0
            || shd_r[`C_IF_DR] == '0;
        hi_zero = shd_r[`C_ISO_P] == '0 || shd_r[`C_ISO_NPC] == '0
            || shd_r[`C_ISO_NPD] == '0 || shd_r[`C_ISO_RC] == '0
            || shd_r[`C_ISO_RD] == '0 || shd_r[`C_NB_HI_NPD] == '0
            || shd_r[`C_NB_HI_RD] == '0 || shd_r[`C_NB_HI_PD] == '0
            || shd_r[`C_NB_HI_RC] == '0 || shd_r[`C_NB_HI_NPC] == '0
            || shd_r[`C_NB_HI_PC] == '0 || shd_r[`C_IF_HI_P] == '0
            || shd_r[`C_IF_HI_NP] == '0;
        bad = 1'b0;
        if (mode_r[`MODE_ISOC_BIT] && !mode_r[`MODE_HP_BIT]) begin
            bad = 1'b1;
        end
        if (s_up_cmd > `LIM_UP_CMD || s_up_dat > `LIM_UP_DATA) begin
            bad = 1'b1;
        end
        if (s_dn > `LIM_DN) begin
            bad = 1'b1;
        end
        if (s_nb_dat > `LIM_NB_DATA || s_nb_rsp > `LIM_NB_RSP
            || s_nb_req > `LIM_NB_REQ) begin
            bad = 1'b1;
        end
        if (s_if > `LIM_INFLIGHT || shd_r[`C_FREE] == '0) begin
            bad = 1'b1;
        end
        if (lo_zero || (mode_r[`MODE_DR_BIT] && dr_zero)
            || (mode_r[`MODE_HP_BIT] && hi_zero)) begin
            bad = 1'b1;
        end
    end

    // ****************************************
    // status, read data and bus answer
    // ****************************************
    logic viol_nxt;
    logic [31:0] rd_nxt;

    always_comb begin
        viol_nxt = CFG_VIOLATION_O;
        if (wr_acc && PADDR_I == ADDR_W'(`OFS_STATUS) && PWDATA_I[`STAT_VIOL_BIT]) begin
            viol_nxt = 1'b0;
        end
        // a violation found in the clear cycle still sticks
        if (warm_edge && bad) begin
            viol_nxt = 1'b1;
        end
        rd_nxt = 32'h00000000;
        if (hit_cnt) begin
            for (int i = 0; i < `CNT_PER_WORD; i++) begin
                rd_nxt[8*i +: CNT_W] = shd_r[int'(cnt_word) * `CNT_PER_WORD + i];
            end
        end else if (PADDR_I == ADDR_W'(`OFS_MODE)) begin
            rd_nxt[3:0] = mode_r;
        end else if (PADDR_I == ADDR_W'(`OFS_TUNE)) begin
            rd_nxt = TUNE_O;
        end else if (PADDR_I == ADDR_W'(`OFS_STATUS)) begin
            rd_nxt[`STAT_VIOL_BIT] = CFG_VIOLATION_O;
            rd_nxt[`STAT_DR_BIT] = act_mode_r[`MODE_DR_BIT];
            rd_nxt[`STAT_HP_BIT] = act_mode_r[`MODE_HP_BIT];
            rd_nxt[`STAT_ISOC_BIT] = act_mode_r[`MODE_ISOC_BIT];
            rd_nxt[`STAT_DEMOTE_BIT] = mode_r[`MODE_DEMOTE_BIT];
        end
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            mode_r <= `MODE_RST;
            act_mode_r <= 3'(`MODE_RST);
            TUNE_O <= `TUNE_RST;
            CFG_VIOLATION_O <= 1'b0;
            ISOC_FLOW_EN_O <= 1'b0;
            PRDATA_O <= 32'h00000000;
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            act_mode_r <= act_mode_nxt;
            TUNE_O <= tune_nxt;
            CFG_VIOLATION_O <= viol_nxt;
            ISOC_FLOW_EN_O <= act_mode_nxt[`MODE_ISOC_BIT];
            PREADY_O <= setup;
            PSLVERR_O <= setup && !mapped;
            if (setup) begin
                PRDATA_O <= (PWRITE_I || !mapped) ? 32'h00000000 : rd_nxt;
            end
        end
    end

    // ****************************************
    // request routing
    // ****************************************
    vc_set_classifier u_classifier (
        .clk_i(CLK_I),
        .rst_i(RESET_I),
        .dr_en_i(act_mode_r[`MODE_DR_BIT]),
        .hp_en_i(act_mode_r[`MODE_HP_BIT]),
        .demote_en_i(mode_r[`MODE_DEMOTE_BIT]),
        .req_valid_i(REQ_VALID_I),
        .req_isoc_i(REQ_ISOC_I),
        .req_posted_i(REQ_POSTED_I),
        .req_read_i(REQ_READ_I),
        .req_ppw_i(REQ_PASS_PW_I),
        .req_rppw_i(REQ_RESP_PASS_PW_I),
        .req_coherent_i(REQ_COHERENT_I),
        .req_seq_tag_i(REQ_SEQ_TAG_I),
        .dn_valid_i(DN_VALID_I),
        .dn_src_i(DN_SRC_I),
        .dn_up_isoc_i(DN_UP_ISOC_I),
        .req_class_o(REQ_CLASS_O),
        .req_vc_set_o(REQ_VC_SET_O),
        .req_subch_o(REQ_SUBCH_O),
        .req_valid_o(REQ_VALID_O),
        .dn_valid_o(DN_VALID_O),
        .dn_isoc_o(DN_ISOC_O)
    );
endmodule // upstream_vc_set_router

// ---- dv/upstream_vc_set_router_assertions.sv ----
/* port checker for the upstream VC set router
   assumes one clock domain and the bind at the foot of this file */
`include "vc_router_params.svh"
module vc_router_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic WARM_RESET_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic PREADY_O,
    input wire logic REQ_VALID_I,
    input wire logic REQ_ISOC_I,
    input wire logic REQ_POSTED_I,
    input wire logic REQ_READ_I,
    input wire logic REQ_PASS_PW_I,
    input wire logic REQ_RESP_PASS_PW_I,
    input wire logic REQ_COHERENT_I,
    input wire logic [3:0] REQ_SEQ_TAG_I,
    input wire logic DN_VALID_I,
    input wire vc_router_pkg::dn_src_t DN_SRC_I,
    input wire logic DN_UP_ISOC_I,
    input wire logic REQ_VALID_O,
    input wire vc_router_pkg::req_class_t REQ_CLASS_O,
    input wire vc_router_pkg::vc_set_t REQ_VC_SET_O,
    input wire vc_router_pkg::subch_t REQ_SUBCH_O,
    input wire logic DN_VALID_O,
    input wire logic DN_ISOC_O,
    input wire logic [31:0] TUNE_O,
    input wire logic ISOC_FLOW_EN_O,
    input wire logic CFG_VIOLATION_O
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    logic dr_shape;
    assign dr_shape = REQ_ISOC_I && !REQ_POSTED_I && REQ_READ_I && REQ_PASS_PW_I
        && REQ_RESP_PASS_PW_I && !REQ_COHERENT_I && REQ_SEQ_TAG_I == 4'h0;
    a_disp_class: assert property (REQ_VALID_I && dr_shape |=> REQ_CLASS_O == vc_router_pkg::CLS_DISP)
        else $error("refresh class wrong");
    a_isoc_class: assert property (REQ_VALID_I && REQ_ISOC_I && !dr_shape |=> REQ_CLASS_O == vc_router_pkg::CLS_ISOC)
        else $error("isoc class wrong");
    a_base_low: assert property (REQ_VALID_I && !REQ_ISOC_I |=> REQ_VALID_O && REQ_VC_SET_O == vc_router_pkg::VC_LO)
        else $error("base request off the low set");
    a_only_disp_dr: assert property (REQ_VALID_O && REQ_CLASS_O != vc_router_pkg::CLS_DISP |-> REQ_VC_SET_O != vc_router_pkg::VC_DR)
        else $error("non refresh request on refresh set");
    a_dr_no_post: assert property (REQ_VALID_O && REQ_VC_SET_O == vc_router_pkg::VC_DR |-> REQ_SUBCH_O == vc_router_pkg::SUB_NONPOSTED)
        else $error("refresh set lane wrong");
    a_subch_kind: assert property (REQ_VALID_I |=> REQ_SUBCH_O == ($past(REQ_POSTED_I) ? vc_router_pkg::SUB_POSTED : vc_router_pkg::SUB_NONPOSTED))
        else $error("lane wrong");
    a_core_base: assert property (DN_VALID_I && DN_SRC_I == vc_router_pkg::DN_CORE |=> DN_VALID_O && !DN_ISOC_O)
        else $error("core not on base");
    a_resp_chan: assert property (DN_VALID_I && DN_SRC_I == vc_router_pkg::DN_RESP |=> DN_ISOC_O == $past(DN_UP_ISOC_I))
        else $error("response channel wrong");
    a_tune_now: assert property (PSEL_I && PENABLE_I && PWRITE_I && PREADY_O && PADDR_I == `OFS_TUNE |=> TUNE_O == $past(PWDATA_I))
        else $error("tuning write late");
    a_flow_commit: assert property ($changed(ISOC_FLOW_EN_O) |-> $past(WARM_RESET_I, 2) || $past(WARM_RESET_I, 3) || $past(WARM_RESET_I, 4))
        else $error("flow enable changed without warm reset");
    a_viol_warm: assert property ($rose(CFG_VIOLATION_O) |-> $past(WARM_RESET_I, 2) || $past(WARM_RESET_I, 3) || $past(WARM_RESET_I, 4))
        else $error("violation outside warm reset");
    c_dr: cover property (REQ_VALID_O && REQ_VC_SET_O == vc_router_pkg::VC_DR);
    c_hi: cover property (REQ_VALID_O && REQ_VC_SET_O == vc_router_pkg::VC_HI);
    c_viol: cover property ($rose(CFG_VIOLATION_O));
endmodule // vc_router_checker
bind upstream_vc_set_router vc_router_checker #(.ADDR_W(ADDR_W)) u_vc_router_checker (.*);

// ---- dv/link_chipset_model.sv ----
/* request side of the link chipset: forms upstream requests by kind
   assumes the bench paces valid; fields scramble while idle */
module link_chipset_model (
    input wire logic vld_i,
    input wire logic [2:0] kind_i,
    output logic valid_o,
    output logic isoc_o,
    output logic posted_o,
    output logic read_o,
    output logic ppw_o,
    output logic rppw_o,
    output logic coh_o,
    output logic [3:0] tag_o
);
    // ****************************************
    // request shapes
    // ****************************************
    logic [9:0] f;
    always_comb begin
        f = 10'h2E0;
        case (kind_i)
            3'h0: f[9] = 1'h0;
            3'h2: f[8:7] = 2'h2;
            3'h3: f[3:0] = 4'h1;
            3'h4: f[4] = 1'h1;
            3'h5: f[6] = 1'h0;
            default: ;
        endcase
    end
    // idle fields show the inverse, never a stale request
    assign {isoc_o, posted_o, read_o, ppw_o, rppw_o, coh_o, tag_o} = vld_i ? f : ~f;
    assign valid_o = vld_i;
endmodule // link_chipset_model

// ---- dv/test_upstream_vc_set_router.sv ----
/* self-checking bench of the upstream VC set router
   assumes the router, its package and the link chipset model */
`include "vc_router_params.svh"
module test_upstream_vc_set_router;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK_I = 1'h0, RESET_I = 1'h1, WARM_RESET_I = 1'h0, vld = 1'h0, er;
    logic PSEL_I = 1'h0, PENABLE_I = 1'h0, PWRITE_I = 1'h0, DN_VALID_I = 1'h0;
    logic DN_UP_ISOC_I = 1'h0, PREADY_O, PSLVERR_O, REQ_VALID_O, DN_VALID_O, DN_ISOC_O;
    logic REQ_VALID_I, REQ_ISOC_I, REQ_POSTED_I, REQ_READ_I, REQ_PASS_PW_I;
    logic REQ_RESP_PASS_PW_I, REQ_COHERENT_I, ISOC_FLOW_EN_O, CFG_VIOLATION_O;
    logic [3:0] REQ_SEQ_TAG_I;
    logic [2:0] kind = 3'h0;
    logic [7:0] PADDR_I = 8'h00;
    logic [31:0] PWDATA_I = 32'h0, PRDATA_O, TUNE_O, rd;
    vc_router_pkg::dn_src_t DN_SRC_I = vc_router_pkg::DN_CORE;
    vc_router_pkg::req_class_t REQ_CLASS_O;
    vc_router_pkg::vc_set_t REQ_VC_SET_O;
    vc_router_pkg::subch_t REQ_SUBCH_O;
    int error_cnt = 0, checks = 0, cyc = 0;
    logic [2:0] row_kind [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
    vc_router_pkg::req_class_t row_cls [6] = '{vc_router_pkg::CLS_BASE,
        vc_router_pkg::CLS_DISP, vc_router_pkg::CLS_ISOC, vc_router_pkg::CLS_ISOC,
        vc_router_pkg::CLS_ISOC, vc_router_pkg::CLS_ISOC};
    upstream_vc_set_router u_upstream_vc_set_router (.*);
    link_chipset_model u_link_chipset_model (.vld_i(vld), .kind_i(kind),
        .valid_o(REQ_VALID_I), .isoc_o(REQ_ISOC_I), .posted_o(REQ_POSTED_I),
        .read_o(REQ_READ_I), .ppw_o(REQ_PASS_PW_I), .rppw_o(REQ_RESP_PASS_PW_I),
        .coh_o(REQ_COHERENT_I), .tag_o(REQ_SEQ_TAG_I));
    // ****************************************
    // clock, timeout and tasks
    // ****************************************
    always #10 CLK_I = ~CLK_I;
    always @(posedge CLK_I) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            test_done;
        end
    end
    task test_done;
        if (error_cnt == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        PSEL_I <= 1'h1;
        PWRITE_I <= w;
        PADDR_I <= a;
        PWDATA_I <= d;
        @(posedge CLK_I);
        PENABLE_I <= 1'h1;
        do @(posedge CLK_I); while (PREADY_O !== 1'h1);
        rd = PRDATA_O;
        er = PSLVERR_O;
        PSEL_I <= 1'h0;
        PENABLE_I <= 1'h0;
        @(posedge CLK_I);
    endtask
    task warm;
        WARM_RESET_I <= 1'h1;
        repeat (3) @(posedge CLK_I);
        WARM_RESET_I <= 1'h0;
        repeat (6) @(posedge CLK_I);
    endtask
    task send(input logic [2:0] k);
        kind <= k;
        vld <= 1'h1;
        @(posedge CLK_I);
        vld <= 1'h0;
        @(posedge CLK_I);
    endtask
    function vc_router_pkg::vc_set_t vc_exp(input vc_router_pkg::req_class_t c,
        input logic dr, input logic hp);
        if (c == vc_router_pkg::CLS_DISP && dr) return vc_router_pkg::VC_DR;
        if (c != vc_router_pkg::CLS_BASE && hp) return vc_router_pkg::VC_HI;
        return vc_router_pkg::VC_LO;
    endfunction
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge CLK_I);
        RESET_I <= 1'h0;
        @(posedge CLK_I);
        chk(TUNE_O, 32'h0);
        apb(1'h0, `OFS_MODE, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 10; i++) apb(1'h1, 8'(`OFS_CNT_BASE + 4 * i), 32'h01010101);
        apb(1'h0, 8'h38, 32'h0);
        chk(er, 32'h1);
        chk(rd, 32'h0);
        apb(1'h1, `OFS_TUNE, 32'hA5C30F1E);
        chk(TUNE_O, 32'hA5C30F1E);
        apb(1'h0, `OFS_TUNE, 32'h0);
        chk(rd, 32'hA5C30F1E);
        apb(1'h1, `OFS_MODE, 32'h6);
        chk(ISOC_FLOW_EN_O, 32'h0);
        warm;
        chk(ISOC_FLOW_EN_O, 32'h1);
        chk(CFG_VIOLATION_O, 32'h0);
        for (int m = 0; m < 4; m++) begin
            apb(1'h1, `OFS_MODE, 32'(m));
            warm;
            for (int r = 0; r < 6; r++) begin
                send(row_kind[r]);
                chk(REQ_VALID_O, 32'h1);
                chk(REQ_CLASS_O, row_cls[r]);
                chk(REQ_VC_SET_O, vc_exp(row_cls[r], m[0], m[1]));
                chk(REQ_SUBCH_O, row_kind[r] == 3'h2 ? 32'h0 : 32'h1);
            end
        end
        for (int d = 0; d < 2; d++) begin
            apb(1'h1, `OFS_MODE, d ? 32'h8 : 32'h0);
            for (int s = 0; s < 3; s++) begin
                for (int u = 0; u < 2; u++) begin
                    DN_SRC_I <= vc_router_pkg::dn_src_t'(s);
                    DN_UP_ISOC_I <= 1'(u);
                    DN_VALID_I <= 1'h1;
                    @(posedge CLK_I);
                    DN_VALID_I <= 1'h0;
                    @(posedge CLK_I);
                    chk(DN_ISOC_O, s == 0 ? 0 : (s == 1 ? u & !d : u));
                end
            end
        end
        apb(1'h1, `OFS_CNT_BASE, 32'h01011F01);
        warm;
        chk(CFG_VIOLATION_O, 32'h0);
        apb(1'h1, `OFS_CNT_BASE, 32'h01012001);
        warm;
        chk(CFG_VIOLATION_O, 32'h1);
        apb(1'h1, `OFS_CNT_BASE, 32'h01010101);
        warm;
        chk(CFG_VIOLATION_O, 32'h1);
        apb(1'h1, `OFS_STATUS, 32'h1);
        chk(CFG_VIOLATION_O, 32'h0);
        apb(1'h1, `OFS_MODE, 32'h4);
        warm;
        chk(CFG_VIOLATION_O, 32'h1);
        test_done;
    end
endmodule // test_upstream_vc_set_router
